//--- pkg/mpks_pkg.sv
// Package for the power key and reset sequencer: timing constants, states and the status struct.
package mpks_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 40_000_000;  // System clock rate in hertz.
  localparam int unsigned PWR_ON_MS       = 2000;        // Least power key low time to turn on.
  localparam int unsigned PWR_OFF_MS      = 3100;        // Least power key low time to turn off.
  localparam int unsigned RST_LOW_MS      = 100;         // Least reset low time to reset.
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned PWR_ON_CYC_DEF  = PWR_ON_MS * CYC_PER_MS;
  localparam int unsigned PWR_OFF_CYC_DEF = PWR_OFF_MS * CYC_PER_MS;
  localparam int unsigned RST_LOW_CYC_DEF = RST_LOW_MS * CYC_PER_MS;
  localparam int unsigned RST_PULSE_CYC   = 16;          // Length of the internal reset pulse.
  localparam int unsigned CNT_W           = 28;          // Width of the low-time counters.

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,  // Supply present, module off.
    ST_ON    = 5'h02,  // Module running.
    ST_SHUT  = 5'h04,  // Orderly shutdown in progress.
    ST_RESET = 5'h08,  // Hardware reset pulse in progress.
    ST_DOWN  = 5'h10   // Supply lost; waiting for supply.
  } mpks_state_t;

  // Status returned to the rest of the module.
  typedef struct packed {
    logic power_on;    // Core supplies enabled.
    logic core_rst;    // Core held in reset.
    logic shut_req;    // Ask firmware for orderly shutdown.
    logic auto_mode;   // Power key found tied low at supply-up.
  } mpks_status_t;

endpackage

//--- rtl/mpks_low_timer.sv
// Low-interval timer: measures how long a synchronised active-low input stays low.
`timescale 1ns/1ps
`default_nettype none
module mpks_low_timer
  import mpks_pkg::*;
(
  // Clock and reset.
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // Synchronised input level, high while the pin is low.
  input  wire logic             i_low,
  // Target length in cycles.
  input  wire logic [CNT_W-1:0] i_target,
  // Outputs.
  output logic                  o_reached,  // Level, high once the low time reached the target.
  output logic                  o_hit       // One-cycle pulse on the cycle before the count reaches the target and o_reached rises.
);

  logic [CNT_W-1:0] cnt_ff;      // Cycles spent low so far.
  logic [CNT_W-1:0] nxt_cnt;     // Next counter value.
  wire              at_target = (cnt_ff >= i_target);

  // ************************************************************
  // Counter: restarts on release and saturates at the target.
  // ************************************************************
  assign nxt_cnt   = !i_low ? '0 : (at_target ? cnt_ff : cnt_ff + CNT_W'(1));
  assign o_reached = at_target;
  assign o_hit     = i_low && (cnt_ff == i_target - CNT_W'(1));

  // Counter register, cleared by reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // A release must clear the count on the next edge.
  property p_restart;
    @(posedge i_sys_clk) disable iff (i_rst) !i_low |=> (cnt_ff == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("Low count not cleared on release.");

endmodule
`default_nettype wire

//--- rtl/mpks_sequencer.sv
// Power key and reset pin sequencer for a cellular module.
`timescale 1ns/1ps
`default_nettype none

module mpks_sequencer
  import mpks_pkg::*;
#(
  parameter int unsigned PWR_ON_CYC  = PWR_ON_CYC_DEF,   // Power-on hold in cycles.
  parameter int unsigned PWR_OFF_CYC = PWR_OFF_CYC_DEF,  // Power-off hold in cycles.
  parameter int unsigned RST_CYC     = RST_LOW_CYC_DEF   // Reset hold in cycles.
) (
  // Clock and reset.
  input  wire logic    i_sys_clk,
  input  wire logic    i_rst,
  // Control pins, active low, asynchronous.
  input  wire logic    i_power_key_n,
  input  wire logic    i_reset_n,
  // Supply monitor pin, high while supply is good, asynchronous.
  input  wire logic    i_supply_ok,
  // Firmware side, same clock, one-cycle pulses.
  input  wire logic    i_sw_shutdown,   // Software shutdown command.
  input  wire logic    i_sw_reset,      // Software reset command.
  input  wire logic    i_shut_done,     // Firmware finished orderly shutdown.
  // Status outputs.
  output var mpks_status_t o_status,
  output logic [4:0]   o_state
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] sync1_ff;  // First stage; read only by the second stage.
  logic [2:0] sync2_ff;  // Second stage: {supply, reset_n, key_n}.

  // Two-flop synchroniser; pins reset to their idle levels except supply.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sync1_ff <= 3'h3;
      sync2_ff <= 3'h3;
    end else begin
      sync1_ff <= {i_supply_ok, i_reset_n, i_power_key_n};
      sync2_ff <= sync1_ff;
    end
  end

  wire key_low   = !sync2_ff[0];  // Power key held low.
  wire rst_low   = !sync2_ff[1];  // Reset pin held low.
  wire supply_ok = sync2_ff[2];   // Supply present.

  // ************************************************************
  // Low-interval timers
  // ************************************************************
  wire key_on_reached;   // Key low for power-on time.
  wire key_off_reached;  // Key low for power-off time.
  wire rst_reached;      // Reset low for reset time.
  wire key_low_run;      // Key low while running; a power-on press counts towards shutdown only after ON is entered.
  logic key_armed_ff;    // Key held long enough while running; act on release.
  logic rst_armed_ff;    // Reset held long enough; act on release.

  mpks_low_timer u_key_on (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_low     (key_low),
    .i_target  (CNT_W'(PWR_ON_CYC)),
    .o_reached (key_on_reached),
    .o_hit     ()
  );

  mpks_low_timer u_key_off (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_low     (key_low_run),
    .i_target  (CNT_W'(PWR_OFF_CYC)),
    .o_reached (key_off_reached),
    .o_hit     ()
  );

  mpks_low_timer u_rst (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_low     (rst_low),
    .i_target  (CNT_W'(RST_CYC)),
    .o_reached (rst_reached),
    .o_hit     ()
  );

  // ************************************************************
  // State machine
  // ************************************************************
  mpks_state_t state_ff;      // Current state.
  mpks_state_t nxt_state;     // Next state.
  logic        auto_ff;       // Key tied low at supply-up.
  logic        nxt_auto;      // Next auto flag.
  logic [4:0]  pulse_ff;      // Reset pulse counter.
  logic        first_ff;      // First cycle after supply returns.
  logic        nxt_key_armed; // Next key arm.
  logic        nxt_rst_armed; // Next reset arm.

  wire pulse_done = (pulse_ff == 5'(RST_PULSE_CYC - 1));

  // The shutdown hold is measured only while running, so the part of a power-on press before ON does not count towards it.
  assign key_low_run = key_low && (state_ff == ST_ON);

  // Arm on the hold time; the action follows the release.
  assign nxt_key_armed = (state_ff == ST_ON) && !auto_ff && (key_armed_ff || (key_low && key_off_reached));
  assign nxt_rst_armed = (state_ff == ST_ON) && (rst_armed_ff || (rst_low && rst_reached));

  // Next-state logic; supply loss wins over every other event.
  always_comb begin
    nxt_state = state_ff;
    nxt_auto  = auto_ff;
    if (!supply_ok) begin
      nxt_state = ST_DOWN;
      nxt_auto  = 1'b0;
    end else begin
      case (state_ff)
        ST_DOWN: begin
          nxt_state = ST_OFF;
          // A key already low as supply appears is taken as tied low.
          nxt_auto  = key_low;
        end
        ST_OFF: begin
          // A key that falls after supply is seen must be held the full time.
          if (auto_ff) begin
            nxt_state = ST_ON;
          end else if (key_low && key_on_reached) begin
            nxt_state = ST_ON;
          end
        end
        ST_ON: begin
          if (key_armed_ff && !key_low) begin
            nxt_state = ST_SHUT;
          end else if ((rst_armed_ff && !rst_low) || i_sw_reset) begin
            nxt_state = ST_RESET;
          end else if (i_sw_shutdown && !auto_ff) begin
            nxt_state = ST_SHUT;
          end
        end
        ST_SHUT: begin
          if (i_shut_done) begin
            nxt_state = ST_OFF;
          end
        end
        ST_RESET: begin
          if (pulse_done) begin
            nxt_state = ST_ON;
          end
        end
        default: begin
          nxt_state = ST_DOWN;
        end
      endcase
    end
  end

  // State and flag registers.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff     <= ST_DOWN;
      auto_ff      <= 1'b0;
      first_ff     <= 1'b0;
      key_armed_ff <= 1'b0;
      rst_armed_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      auto_ff      <= nxt_auto;
      first_ff     <= (state_ff == ST_DOWN) && supply_ok;
      key_armed_ff <= nxt_key_armed;
      rst_armed_ff <= nxt_rst_armed;
    end
  end

  // Reset pulse length counter.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || state_ff != ST_RESET) begin
      pulse_ff <= '0;
    end else begin
      pulse_ff <= pulse_ff + 5'h01;
    end
  end

  // ************************************************************
  // Outputs, decoded from the state and auto flip-flops
  // ************************************************************
  assign o_status.power_on  = state_ff[1] | state_ff[2] | state_ff[3];
  assign o_status.core_rst  = !state_ff[1] && !state_ff[2];
  assign o_status.shut_req  = state_ff[2];
  assign o_status.auto_mode = auto_ff;
  assign o_state            = state_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_on_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == ST_OFF) && $past(state_ff) == ST_OFF && supply_ok && !auto_ff && !first_ff
      && !key_on_reached |=> (state_ff != ST_ON);
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("Powered on before key hold time.");

  property p_shut_release;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == ST_ON) && $past(state_ff) == ST_ON && (nxt_state == ST_SHUT) && !i_sw_shutdown
      |-> key_armed_ff && !key_low;
  endproperty
  a_shut_release: assert property (p_shut_release) else $error("Shutdown without held key.");

  property p_reset_pulse;
    @(posedge i_sys_clk) disable iff (i_rst)
      $rose(state_ff == ST_RESET) && supply_ok |-> o_status.core_rst [*8];
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("Reset pulse too short.");

  property p_auto_no_sw;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == ST_ON) && auto_ff && supply_ok && !i_sw_reset && !(rst_armed_ff && !rst_low)
      |=> (state_ff == ST_ON);
  endproperty
  a_auto_no_sw: assert property (p_auto_no_sw) else $error("Auto mode left running state.");

  property p_supply_loss;
    @(posedge i_sys_clk) disable iff (i_rst)
      !supply_ok |=> (state_ff == ST_DOWN) && !o_status.power_on;
  endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("No abrupt shutdown on supply loss.");

  property p_auto_on;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == ST_OFF) && auto_ff && supply_ok |=> (state_ff == ST_ON);
  endproperty
  a_auto_on: assert property (p_auto_on) else $error("Auto power-on missing.");

  property p_sw_reset;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == ST_ON) && i_sw_reset && supply_ok && !(key_armed_ff && !key_low) |=> (state_ff == ST_RESET);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("Software reset ignored.");

  property p_rst_arm;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == ST_ON) && !rst_low && !rst_armed_ff |=> !rst_armed_ff;
  endproperty
  a_rst_arm: assert property (p_rst_arm) else $error("Reset armed without hold.");

  c_power_on: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(state_ff == ST_ON));
  c_shutdown: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(state_ff == ST_SHUT));
  c_reset:    cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(state_ff == ST_RESET));
  c_supply:   cover property (@(posedge i_sys_clk) disable iff (i_rst) $fell(supply_ok));

endmodule
`default_nettype wire

//--- tb/mpks_host_model.sv
// Host-side pin driver model for the power key and reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module mpks_host_model #(
  parameter int unsigned GAP_CYC = 8  // Scaled settling gap between supply-up and the first key press.
) (
  // Clock.
  input  wire logic i_sys_clk,
  // Pins towards the sequencer.
  output logic      o_power_key_n,  // Open-drain key line with pull-up.
  output logic      o_reset_n,      // Open-drain reset line with pull-up.
  output logic      o_supply_ok     // Supply monitor level.
);
  // ************************************************************
  // Pin driving
  // ************************************************************
  // Released open-drain lines sit at their pull-up level, and the supply starts absent.
  initial begin
    o_power_key_n = 1'b1;
    o_reset_n     = 1'b1;
    o_supply_ok   = 1'b0;
  end

  // Bring the supply up, optionally with the key strapped low, then hold off the key.
  task automatic supply_up(input logic key_tied);
    @(posedge i_sys_clk);
    o_power_key_n <= ~key_tied;
    o_supply_ok   <= 1'b1;
    repeat (GAP_CYC) @(posedge i_sys_clk);
  endtask

  // Drop the supply; scenarios use this in mid-run on purpose to test abrupt loss.
  task automatic supply_down();
    @(posedge i_sys_clk);
    o_supply_ok <= 1'b0;
  endtask

  // Hold the key (sel 0) or reset line (sel 1) low for n cycles, then release it.
  task automatic pulse(input logic sel, input int unsigned n);
    @(posedge i_sys_clk);
    if (sel) begin
      o_reset_n <= 1'b0;
    end else begin
      o_power_key_n <= 1'b0;
    end
    repeat (n) @(posedge i_sys_clk);
    o_power_key_n <= 1'b1;
    o_reset_n     <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_mpks_sequencer.sv
// Self-checking testbench for the power key and reset sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_mpks_sequencer;
  import mpks_pkg::*;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  localparam int unsigned ON_C  = 50;  // Shortened power-on hold.
  localparam int unsigned OFF_C = 80;  // Shortened power-off hold.
  localparam int unsigned RST_C = 20;  // Shortened reset hold.
  logic         i_sys_clk, i_rst, i_sw_shutdown, i_sw_reset, i_shut_done;
  wire          key_n, rst_n, sup_ok;  // Pins from the host model.
  mpks_status_t o_status;
  logic [4:0]   o_state, prev;
  logic [4:0]   exp_q[$];              // Expected state changes, oldest first.
  logic         mon_on;                // Monitor enable.
  int           n_fail, tests_run;

  mpks_host_model mpks_host_model_i (.i_sys_clk(i_sys_clk), .o_power_key_n(key_n), .o_reset_n(rst_n),
    .o_supply_ok(sup_ok));
  mpks_sequencer #(.PWR_ON_CYC(ON_C), .PWR_OFF_CYC(OFF_C), .RST_CYC(RST_C)) mpks_sequencer_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_power_key_n(key_n), .i_reset_n(rst_n), .i_supply_ok(sup_ok),
    .i_sw_shutdown(i_sw_shutdown), .i_sw_reset(i_sw_reset), .i_shut_done(i_shut_done),
    .o_status(o_status), .o_state(o_state));

  // Free-running 40 MHz clock.
  initial i_sys_clk = 1'b0;
  always #12.5 i_sys_clk = ~i_sys_clk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Compare one value with its expectation and count it.
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle firmware pulses, given as {shutdown, reset, done}.
  task automatic sw(input logic [2:0] m);
    @(posedge i_sys_clk);
    {i_sw_shutdown, i_sw_reset, i_shut_done} <= m;
    @(posedge i_sys_clk);
    {i_sw_shutdown, i_sw_reset, i_shut_done} <= 3'h0;
  endtask

  // Let a fixed span pass, then every noted change must have shown up.
  task automatic settle(input int unsigned n);
    repeat (n) @(posedge i_sys_clk);
    check(5'(exp_q.size()), 5'h00);
  endtask

  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Output monitor
  // ************************************************************
  // On each state change take the oldest note; an unnoted change meets 0, which a one-hot state never is.
  always @(negedge i_sys_clk) begin
    if (!i_rst && mon_on && o_state !== prev) begin
      check(o_state, (exp_q.size() != 0) ? exp_q.pop_front() : 5'h00);
      if (o_state === ST_ON) check(5'({o_status.power_on, o_status.core_rst}), 5'h02);
      if (o_state === ST_RESET) check(5'(o_status.core_rst), 5'h01);
      if (o_state === ST_SHUT) check(5'(o_status.shut_req), 5'h01);
      if (o_state === ST_DOWN) check(5'(o_status.power_on), 5'h00);
    end
    prev <= o_state;
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    n_fail = 0;
    tests_run = 0;
    mon_on = 1'b1;
    prev = 5'h00;
    i_rst = 1'b1;
    {i_sw_shutdown, i_sw_reset, i_shut_done} = 3'h0;
    void'($urandom(7));
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
    check(o_state, ST_DOWN);
    exp_q.push_back(ST_OFF);
    mpks_host_model_i.supply_up(1'b0);
    settle(10);
    check(5'(o_status.auto_mode), 5'h00);
    mpks_host_model_i.pulse(1'b0, 5 + $urandom % 20);
    settle(10);
    exp_q.push_back(ST_ON);
    mpks_host_model_i.pulse(1'b0, ON_C + 10);
    settle(10);
    mpks_host_model_i.pulse(1'b0, ON_C + $urandom % (OFF_C - ON_C - 5));
    settle(10);
    mpks_host_model_i.pulse(1'b1, 2 + $urandom % 12);
    settle(10);
    exp_q.push_back(ST_RESET);
    exp_q.push_back(ST_ON);
    mpks_host_model_i.pulse(1'b1, RST_C + 5);
    settle(40);
    exp_q.push_back(ST_RESET);
    exp_q.push_back(ST_ON);
    sw(3'b010);
    settle(40);
    exp_q.push_back(ST_SHUT);
    exp_q.push_back(ST_OFF);
    sw(3'b100);
    sw(3'b001);
    settle(10);
    exp_q.push_back(ST_ON);
    mpks_host_model_i.pulse(1'b0, ON_C + 10);
    settle(10);
    exp_q.push_back(ST_SHUT);
    mpks_host_model_i.pulse(1'b0, OFF_C + 10);
    settle(10);
    exp_q.push_back(ST_OFF);
    sw(3'b001);
    settle(10);
    // Orderly path: the supply is taken away only once the module is off.
    exp_q.push_back(ST_DOWN);
    mpks_host_model_i.supply_down();
    settle(10);
    exp_q.push_back(ST_OFF);
    mpks_host_model_i.supply_up(1'b0);
    settle(10);
    exp_q.push_back(ST_ON);
    mpks_host_model_i.pulse(1'b0, ON_C + 10);
    settle(10);
    exp_q.push_back(ST_DOWN);
    mpks_host_model_i.supply_down();
    settle(10);
    // Strapped key: the path through OFF is left open, so only the end state is judged.
    mon_on = 1'b0;
    mpks_host_model_i.supply_up(1'b1);
    repeat (20) @(posedge i_sys_clk);
    check(o_state, ST_ON);
    check(5'(o_status.auto_mode), 5'h01);
    mon_on = 1'b1;
    sw(3'b100);
    settle(20);
    exp_q.push_back(ST_RESET);
    exp_q.push_back(ST_ON);
    sw(3'b010);
    settle(40);
    exp_q.push_back(ST_DOWN);
    mpks_host_model_i.supply_down();
    settle(10);
    tally_and_finish();
  end

  // Cut a hang short well beyond the fewer than one thousand cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_fail++;
    $display("ERROR t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
